// [hw/scsr_top.sv]
// serial port configuration and status register with its shift engines
`timescale 1ns/1ps
`default_nettype none
`include "scsr_params.svh"
module scsr_top
  import scsr_pkg::*;
#(
  parameter int DEGLITCH_CYC = `SCSR_DEGLITCH_CYC
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // special function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // master-out data pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  // master-in data pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // slave select pin, active low
  input wire logic slave_select_pin_n_in,
  output logic slave_select_pin_n_out,
  output logic slave_select_pin_n_oe
);
  //////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  wire sel_cfg; // configuration and status
  wire sel_ckr; // clock rate
  wire sel_dat; // data
  wire sel_ctl; // control
  assign sel_cfg = addr_hit(sfr_addr, `SCSR_ADDR_CFG);
  assign sel_ckr = addr_hit(sfr_addr, `SCSR_ADDR_CKR);
  assign sel_dat = addr_hit(sfr_addr, `SCSR_ADDR_DAT);
  assign sel_ctl = addr_hit(sfr_addr, `SCSR_ADDR_CTL);

  wire wr_cfg;
  wire wr_ckr;
  wire wr_dat;
  wire wr_ctl;
  wire rd_dat;
  assign wr_cfg = sfr_wr && sel_cfg;
  assign wr_ckr = sfr_wr && sel_ckr;
  assign wr_dat = sfr_wr && sel_dat;
  assign wr_ctl = sfr_wr && sel_ctl;
  assign rd_dat = sfr_rd && sel_dat;

  //////////////////////////////////////////////////////////////////////////
  // software settings
  logic master_select_reg; // 1 = master
  logic clock_phase_reg; // 1 = second edge
  logic clock_idle_level_reg; // sck idle level
  scsr_mode_t select_mode_field_reg; // select pin usage
  logic port_enable_reg; // port on
  logic [7:0] clock_rate_reg; // master half-period divider

  // only the writable bits are taken; status bits ignore writes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      master_select_reg <= 1'(`SCSR_CFG_RESET >> `SCSR_CFG_MASTER);
      clock_phase_reg <= 1'b0;
      clock_idle_level_reg <= 1'b0;
      select_mode_field_reg <= `SCSR_MODE_RESET;
      port_enable_reg <= 1'b0;
      clock_rate_reg <= `SCSR_CKR_RESET;
    end else begin
      if (wr_cfg) begin
        master_select_reg <= sfr_wdata[`SCSR_CFG_MASTER];
        clock_phase_reg <= sfr_wdata[`SCSR_CFG_PHASE];
        clock_idle_level_reg <= sfr_wdata[`SCSR_CFG_POL];
      end
      if (wr_ctl) begin
        select_mode_field_reg <= sfr_wdata[`SCSR_CTL_MODE_HI:`SCSR_CTL_MODE_LO];
        port_enable_reg <= sfr_wdata[`SCSR_CTL_ENABLE];
      end
      if (wr_ckr) begin
        clock_rate_reg <= sfr_wdata;
      end
    end
  end

  wire master_on; // enabled master
  wire slave_on; // enabled slave
  wire mode_4wire; // select pin is an input
  assign master_on = port_enable_reg && master_select_reg;
  assign slave_on = port_enable_reg && !master_select_reg;
  assign mode_4wire = (select_mode_field_reg == `SCSR_MODE_4WIRE);

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers: select pin, miso, and link events
  localparam int NSYNC = 5;
  localparam int S_SS = 0;
  localparam int S_MISO = 1;
  localparam int S_DONE = 2;
  localparam int S_EDGE = 3;
  localparam int S_BUSY = 4;
  localparam logic [NSYNC-1:0] SYNC_INIT = 5'h01;

  scsr_link_if lk ();

  wire [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg; // first stage, read only by second stage
  logic [NSYNC-1:0] sync2_reg; // usable
  assign async_in = {lk.busy, lk.edge_tgl, lk.done_tgl, miso_in, slave_select_pin_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          sync1_reg[gi] <= SYNC_INIT[gi];
          sync2_reg[gi] <= SYNC_INIT[gi];
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // toggle events become one-cycle pulses
  logic done_seen_reg;
  logic edge_seen_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      done_seen_reg <= 1'b0;
      edge_seen_reg <= 1'b0;
    end else begin
      done_seen_reg <= sync2_reg[S_DONE];
      edge_seen_reg <= sync2_reg[S_EDGE];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // select pin de-glitch: a level must hold DEGLITCH_CYC cycles
  logic ss_filt_reg; // filtered select pin, active low
  logic [7:0] dg_cnt_reg; // stability counter
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ss_filt_reg <= 1'b1;
      dg_cnt_reg <= 8'h00;
    end else if (sync2_reg[S_SS] == ss_filt_reg) begin
      dg_cnt_reg <= 8'h00;
    end else if (dg_cnt_reg == 8'(DEGLITCH_CYC - 1)) begin
      ss_filt_reg <= sync2_reg[S_SS];
      dg_cnt_reg <= 8'h00;
    end else begin
      dg_cnt_reg <= dg_cnt_reg + 8'h01;
    end
  end

  // shifter idle unless an enabled slave, selected if in 4-wire mode
  logic link_clear_reg;
  logic [1:0] clr_dly_reg; // recent clear history
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      link_clear_reg <= 1'b1;
      clr_dly_reg <= 2'h3;
    end else begin
      link_clear_reg <= !slave_on || (mode_4wire && ss_filt_reg);
      clr_dly_reg <= {clr_dly_reg[0], link_clear_reg};
    end
  end

  // a clear zeroes the toggles; mask that
  wire slave_done; // slave byte end
  wire slave_edge; // slave clock activity
  assign slave_done = slave_on && (clr_dly_reg == 2'h0) && (sync2_reg[S_DONE] != done_seen_reg);
  assign slave_edge = slave_on && (clr_dly_reg == 2'h0) && (sync2_reg[S_EDGE] != edge_seen_reg);

  //////////////////////////////////////////////////////////////////////////
  // transmit buffer and slave transmit word
  logic [7:0] tx_buf_reg;
  logic tx_empty_reg;
  logic [7:0] tx_word_reg; // byte handed to the link shifter
  logic tx_valid_reg; // link shifter holds a byte
  scsr_mstate_t mstate_reg;

  wire master_start; // buffer moves into the master shifter
  wire slave_load; // buffer moves into the slave shifter
  assign master_start = master_on && (mstate_reg == SCSR_M_IDLE) && !tx_empty_reg;
  assign slave_load = slave_on && !tx_empty_reg && (!tx_valid_reg || slave_done);

  // a write while the buffer is full is dropped
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_buf_reg <= 8'h00;
      tx_empty_reg <= 1'b1;
      tx_word_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
    end else begin
      if (wr_dat && tx_empty_reg) begin
        tx_buf_reg <= sfr_wdata;
        tx_empty_reg <= 1'b0;
      end else if (master_start || slave_load) begin
        tx_empty_reg <= 1'b1;
      end
      if (slave_load) begin
        tx_word_reg <= tx_buf_reg;
        tx_valid_reg <= 1'b1;
      end else if (slave_done || !slave_on) begin
        tx_valid_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // master engine: 16 half periods, one more for phase 1
  logic [7:0] div_cnt_reg; // cycles left in this half period
  logic [4:0] half_reg; // half period index
  logic [7:0] mshift_reg; // master shift register
  logic sck_phase_reg; // sck relative to idle

  wire half_end;
  wire [4:0] half_last;
  wire m_sample; // last cycle of a data bit
  wire m_done; // master byte end
  wire [7:0] m_word; // shift register after this sample
  assign half_end = (mstate_reg == SCSR_M_RUN) && (div_cnt_reg == 8'h00);
  assign half_last = clock_phase_reg ? `SCSR_HALF_LAST_PH1 : `SCSR_HALF_LAST_PH0;
  assign m_sample = half_end && (half_reg[0] ^ clock_phase_reg) && (half_reg != 5'h00);
  assign m_done = half_end && (half_reg == half_last);
  assign m_word = {mshift_reg[6:0], sync2_reg[S_MISO]};

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mstate_reg <= SCSR_M_IDLE;
      div_cnt_reg <= 8'h00;
      half_reg <= 5'h00;
      mshift_reg <= 8'h00;
      sck_phase_reg <= 1'b0;
    end else begin
      case (mstate_reg)
        SCSR_M_IDLE: begin
          sck_phase_reg <= 1'b0;
          if (master_start) begin
            mshift_reg <= tx_buf_reg;
            div_cnt_reg <= clock_rate_reg;
            half_reg <= 5'h00;
            mstate_reg <= SCSR_M_RUN;
          end
        end
        SCSR_M_RUN: begin
          if (!master_on) begin
            // disabled mid-byte: abandon it
            mstate_reg <= SCSR_M_IDLE;
          end else if (div_cnt_reg != 8'h00) begin
            div_cnt_reg <= div_cnt_reg - 8'h01;
          end else begin
            div_cnt_reg <= clock_rate_reg;
            half_reg <= half_reg + 5'h01;
            if (m_sample) begin
              mshift_reg <= m_word;
            end
            // 16 edges; phase 1 ends with a quiet half period
            if (half_reg < 5'h10) begin
              sck_phase_reg <= ~sck_phase_reg;
            end
            if (m_done) begin
              mstate_reg <= SCSR_M_IDLE;
            end
          end
        end
        default: begin
          mstate_reg <= SCSR_M_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive buffer: a byte arriving while full is lost
  logic [7:0] rx_buf_reg;
  logic rx_empty_reg;
  wire byte_done;
  wire [7:0] byte_in;
  assign byte_done = slave_done || m_done;
  assign byte_in = m_done ? m_word : lk.rx_word;

  // arrival wins over a read in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_buf_reg <= 8'h00;
      rx_empty_reg <= 1'b1;
    end else if (byte_done && (rx_empty_reg || rd_dat)) begin
      rx_buf_reg <= byte_in;
      rx_empty_reg <= 1'b0;
    end else if (rd_dat) begin
      rx_empty_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // slave shift-empty status
  logic shift_empty_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn || !slave_on) begin
      shift_empty_reg <= 1'b1;
    end else if (slave_load) begin
      shift_empty_reg <= 1'b0;
    end else if (slave_done) begin
      shift_empty_reg <= tx_empty_reg;
    end else if (slave_edge) begin
      shift_empty_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status view and read port
  wire transfer_busy;
  wire selected_slave_flag;
  wire select_pin_raw;
  wire shift_empty;
  wire receive_empty;
  wire [7:0] cfg_view;
  wire [7:0] ctl_view;
  assign transfer_busy = (mstate_reg == SCSR_M_RUN) || (slave_on && sync2_reg[S_BUSY]);
  assign selected_slave_flag = !ss_filt_reg;
  assign select_pin_raw = sync2_reg[S_SS];
  assign shift_empty = master_select_reg || shift_empty_reg;
  assign receive_empty = master_select_reg || rx_empty_reg;
  assign cfg_view = {transfer_busy, master_select_reg, clock_phase_reg,
                     clock_idle_level_reg, selected_slave_flag, select_pin_raw,
                     shift_empty, receive_empty};
  assign ctl_view = {4'h0, select_mode_field_reg, tx_empty_reg, port_enable_reg};

  // read data registered; reading the config register changes nothing
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sel_cfg) begin
        sfr_rdata <= cfg_view;
      end else if (sel_ctl) begin
        sfr_rdata <= ctl_view;
      end else if (sel_ckr) begin
        sfr_rdata <= clock_rate_reg;
      end else if (sel_dat) begin
        sfr_rdata <= rx_buf_reg;
      end else begin
        sfr_rdata <= 8'h00; // unmapped
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link shifter and pins
  assign lk.sclk_in = sck_in;
  assign lk.mosi = mosi_in;
  assign lk.cfg_pol = clock_idle_level_reg;
  assign lk.cfg_pha = clock_phase_reg;
  assign lk.clear = link_clear_reg;
  assign lk.tx_word = tx_word_reg;

  scsr_link u_link (
    .lk(lk.link)
  );

  assign sck_out = clock_idle_level_reg ^ sck_phase_reg;
  assign sck_oe = master_on;
  assign mosi_out = mshift_reg[7];
  assign mosi_oe = master_on;
  assign miso_out = lk.miso;
  assign miso_oe = slave_on && (!mode_4wire || !ss_filt_reg);
  assign slave_select_pin_n_out = select_mode_field_reg[0];
  assign slave_select_pin_n_oe = port_enable_reg && select_mode_field_reg[1];
endmodule
`default_nettype wire

// [inc/scsr_params.svh]
// constants for the serial port configuration and status block
`ifndef SCSR_PARAMS_SVH
`define SCSR_PARAMS_SVH

// register addresses on the special function register bus
`define SCSR_ADDR_CFG 8'hA1
`define SCSR_ADDR_CKR 8'hA2
`define SCSR_ADDR_DAT 8'hA3
`define SCSR_ADDR_CTL 8'hF8

// configuration and status register fields
`define SCSR_CFG_BUSY 7
`define SCSR_CFG_MASTER 6
`define SCSR_CFG_PHASE 5
`define SCSR_CFG_POL 4
`define SCSR_CFG_SELECTED 3
`define SCSR_CFG_PIN_RAW 2
`define SCSR_CFG_SHIFT_EMPTY 1
`define SCSR_CFG_RX_EMPTY 0

// control register fields
`define SCSR_CTL_MODE_HI 3
`define SCSR_CTL_MODE_LO 2
`define SCSR_CTL_TX_EMPTY 1
`define SCSR_CTL_ENABLE 0

// reset values
`define SCSR_CFG_RESET 8'h07
`define SCSR_CTL_RESET 8'h06
`define SCSR_CKR_RESET 8'h00
`define SCSR_MODE_RESET 2'h1

// select mode encodings
`define SCSR_MODE_3WIRE 2'h0
`define SCSR_MODE_4WIRE 2'h1

// timing counts
`define SCSR_BITS 8
`define SCSR_DEGLITCH_CYC 2
`define SCSR_HALF_LAST_PH0 5'h0F
`define SCSR_HALF_LAST_PH1 5'h10

`endif

// [inc/scsr_pkg.sv]
// types shared by the serial port configuration and status block
package scsr_pkg;
  // master engine states, one-hot
  typedef enum logic [1:0] {
    SCSR_M_IDLE = 2'b01,
    SCSR_M_RUN = 2'b10
  } scsr_mstate_t;

  // select mode field
  typedef logic [1:0] scsr_mode_t;

  // one serial byte
  typedef logic [7:0] scsr_byte_t;
endpackage

// [inc/scsr_link_if.sv]
// signals between the system-clock core and the link-clock slave shifter
`timescale 1ns/1ps
`default_nettype none
interface scsr_link_if;
  logic sclk_in; // serial clock pin, clock of the link domain
  logic mosi; // serial data in, link domain
  logic cfg_pol; // clock idle level, static while enabled
  logic cfg_pha; // clock phase, static while enabled
  logic clear; // holds the shifter idle, level from system domain
  logic [7:0] tx_word; // byte to send, stable between byte ends
  logic miso; // serial data out
  logic [7:0] rx_word; // last byte received, stable until next byte end
  logic done_tgl; // flips at each byte end
  logic edge_tgl; // flips at each sampling edge
  logic busy; // level, high while a byte is part way through

  modport sys (
    output sclk_in, mosi, cfg_pol, cfg_pha, clear, tx_word,
    input miso, rx_word, done_tgl, edge_tgl, busy
  );
  modport link (
    input sclk_in, mosi, cfg_pol, cfg_pha, clear, tx_word,
    output miso, rx_word, done_tgl, edge_tgl, busy
  );
endinterface
`default_nettype wire

// [hw/scsr_link.sv]
// slave-mode shifter running on the serial clock from the far master
`timescale 1ns/1ps
`default_nettype none
module scsr_link (
  // link side of the core
  scsr_link_if.link lk
);
  //////////////////////////////////////////////////////////////////////////
  // clock selection
  // inverting the pin puts the sampling edge on the rising edge of lclk;
  // the config bits must not change while enabled or lclk may glitch
  wire lclk; // sampling edge is posedge
  assign lclk = lk.sclk_in ^ (lk.cfg_pol ^ lk.cfg_pha);

  logic [2:0] bit_cnt_reg; // bits taken in this byte
  logic [6:0] rx_shift_reg; // partial byte
  logic [7:0] rx_word_reg; // completed byte
  logic done_tgl_reg; // byte end event
  logic edge_tgl_reg; // sampling edge event
  logic started_reg; // any sampling edge since clear
  logic busy_reg; // mid-byte level
  logic out_reg; // launched data bit

  //////////////////////////////////////////////////////////////////////////
  // sampling edge: data centred in its bit is taken here
  // the clear is asynchronous because this clock may stand still
  always_ff @(posedge lclk or posedge lk.clear) begin
    if (lk.clear) begin
      bit_cnt_reg <= 3'h0;
      rx_shift_reg <= 7'h00;
      rx_word_reg <= 8'h00;
      done_tgl_reg <= 1'b0;
      edge_tgl_reg <= 1'b0;
      started_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      edge_tgl_reg <= ~edge_tgl_reg;
      started_reg <= 1'b1;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_shift_reg <= {rx_shift_reg[5:0], lk.mosi};
      busy_reg <= (bit_cnt_reg != 3'h7);
      // last bit: hand the byte over
      if (bit_cnt_reg == 3'h7) begin
        rx_word_reg <= {rx_shift_reg, lk.mosi};
        done_tgl_reg <= ~done_tgl_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // launch edge: next bit goes out half a bit before it is sampled
  always_ff @(negedge lclk or posedge lk.clear) begin
    if (lk.clear) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= lk.tx_word[3'h7 - bit_cnt_reg];
    end
  end

  // phase 0 needs the first bit before any edge arrives
  assign lk.miso = (!started_reg && !lk.cfg_pha) ? lk.tx_word[7] : out_reg;
  assign lk.rx_word = rx_word_reg;
  assign lk.done_tgl = done_tgl_reg;
  assign lk.edge_tgl = edge_tgl_reg;
  assign lk.busy = busy_reg;
endmodule
`default_nettype wire

// [tb/scsr_top_asserts.sv]
// port-level checker for the serial configuration and status block
`timescale 1ns/1ps
`default_nettype none
module scsr_top_chk (
  // clock, reset and register bus
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // pin drivers
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic slave_select_pin_n_out,
  input wire logic slave_select_pin_n_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // shadows of the writable fields, taken on the same edge as the block
  logic [2:0] cfg_sh; // master, phase, idle level
  logic en_sh; // port on
  logic [1:0] mode_sh; // select mode
  wire logic want_mst = en_sh & cfg_sh[2];
  wire logic want_slv = en_sh & ~cfg_sh[2];
  wire logic want_ss = en_sh & mode_sh[1];
  wire logic hit = sfr_addr == 8'hA1 || sfr_addr == 8'hA2 || sfr_addr == 8'hA3
    || sfr_addr == 8'hF8;
  // follow register writes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_sh <= 3'h0;
      en_sh <= 1'b0;
      mode_sh <= 2'h1;
    end else if (sfr_wr && sfr_addr == 8'hA1) begin
      cfg_sh <= sfr_wdata[6:4];
    end else if (sfr_wr && sfr_addr == 8'hF8) begin
      en_sh <= sfr_wdata[0];
      mode_sh <= sfr_wdata[3:2];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // a read of the configuration register
  sequence s_cfg_read;
    sfr_rd && !sfr_wr && sfr_addr == 8'hA1;
  endsequence
  a_oe_exclusive: assert property (!(mosi_oe && miso_oe))
    else $error("both data drivers on");
  a_master_pins: assert property (sck_oe == mosi_oe)
    else $error("clock and data enables differ");
  a_master_enable: assert property ($changed(want_mst) |-> ##[0:1] sck_oe == want_mst)
    else $error("master drive does not follow enable");
  a_slave_drive: assert property (miso_oe |-> want_slv || $past(want_slv))
    else $error("slave data driven while not enabled slave");
  a_select_oe: assert property ($changed(want_ss) |-> ##[0:1] slave_select_pin_n_oe == want_ss)
    else $error("select drive does not follow mode");
  a_select_level: assert property ($changed(mode_sh) |-> ##[0:1] slave_select_pin_n_out == mode_sh[0])
    else $error("select level does not follow mode");
  a_idle_level: assert property ($rose(sck_oe) |-> sck_out == cfg_sh[0])
    else $error("clock not at idle level");
  a_cfg_readback: assert property (s_cfg_read |=> sfr_rdata[6:4] == $past(cfg_sh))
    else $error("config fields read back wrong");
  a_master_empties: assert property (s_cfg_read ##0 cfg_sh[2] |=> sfr_rdata[1:0] == 2'b11)
    else $error("empty flags not set as master");
  a_unmapped_zero: assert property (sfr_rd && !hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind scsr_top scsr_top_chk chk (.clk_sys(clk_sys), .resetn(resetn), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .slave_select_pin_n_out(slave_select_pin_n_out),
  .slave_select_pin_n_oe(slave_select_pin_n_oe));
`default_nettype wire

// [tb/scsr_far_dev.sv]
// far-side model: master for slave tests, slave for master tests
`timescale 1ns/1ps
`default_nettype none
module scsr_far_dev (
  // link clock and setup
  input wire logic lclk,
  input wire logic pol,
  input wire logic pha,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  // wire levels
  input wire logic sck_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  input wire logic ss_n_w,
  // drives and results
  output logic sck_d,
  output logic mosi_d,
  output logic miso_d,
  output logic ss_n_d,
  output logic busy,
  output logic [7:0] rx_byte
);
  logic [8:0] sh = 9'h000; // outgoing bits, msb on the wire
  logic [5:0] n = 6'h00; // half-step count
  logic run = 1'b0; // frame as master
  logic sck_r = 1'b0; // own clock
  // released data lines show the inverse of the last bit, not a held value; a released clock sits at pol
  assign sck_d = run ? sck_r : pol;
  assign ss_n_d = ~run;
  assign busy = run;
  assign mosi_d = run ? sh[8] : ~sh[8];
  assign miso_d = ~ss_n_w ? sh[8] : ~sh[8];
  // phase 0 shows the first bit before the first edge, phase 1 after it
  task automatic load;
    sh = pha ? {~tx_byte[7], tx_byte} : {tx_byte, 1'b0};
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // master frame: select, lead-in, sixteen edges, lead-out
  always @(posedge lclk) begin
    if (!run) begin
      if (go) begin
        run <= 1'b1;
        n <= 6'h00;
        sck_r <= pol;
        load;
      end
    end else begin
      n <= n + 6'h01;
      if (n >= 6'h04 && n <= 6'h22 && !n[0]) sck_r <= ~sck_r;
      if (n == 6'h26) run <= 1'b0;
    end
  end
  // sample on one edge kind, shift on the other
  always @(sck_w) begin
    if ((run || !ss_n_w) && (sck_w === 1'b0 || sck_w === 1'b1)) begin
      if (sck_w == (pol ~^ pha)) rx_byte = {rx_byte[6:0], run ? miso_w : mosi_w};
      else sh = {sh[7:0], 1'b0};
    end
  end
  // selected as slave: reload the reply
  always @(negedge ss_n_w) load;
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the serial configuration and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import scsr_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, lclk = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, ss_low = 1'b0, pend = 1'b0;
  logic p_pol = 1'b0, p_pha = 1'b0, p_go = 1'b0;
  scsr_byte_t p_tx = 8'h00, d_tx, pt;
  wire logic [7:0] sfr_rdata, p_rx;
  wire logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe;
  wire logic p_sck, p_mosi, p_miso, p_ss_n, p_busy;
  int fails = 0, total_checks = 0;
  logic [15:0] expq[$];
  logic [15:0] nq;
  logic [31:0] seed = 32'h23B6335B;
  // pin levels from every party's enable
  wire logic sck_w = sck_oe ? sck_out : p_sck;
  wire logic mosi_w = mosi_oe ? mosi_out : p_mosi;
  wire logic miso_w = miso_oe ? miso_out : p_miso;
  wire logic ss_n_w = ss_n_oe ? ss_n_out : (p_ss_n & ~ss_low);
  always #5 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #15 lclk = ~lclk;
  end
  scsr_top #(.DEGLITCH_CYC(2)) dut (.clk_sys, .resetn, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w),
    .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe,
    .slave_select_pin_n_in(ss_n_w), .slave_select_pin_n_out(ss_n_out),
    .slave_select_pin_n_oe(ss_n_oe));
  scsr_far_dev far (.lclk, .pol(p_pol), .pha(p_pha), .go(p_go), .tx_byte(p_tx), .sck_w,
    .mosi_w, .miso_w, .ss_n_w, .sck_d(p_sck), .mosi_d(p_mosi), .miso_d(p_miso),
    .ss_n_d(p_ss_n), .busy(p_busy), .rx_byte(p_rx));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  // read with an expected value under a mask, noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    expq.push_back({m, e & m});
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
  endtask
  task automatic wait_far(input logic v);
    repeat (400) if (p_busy !== v) @(posedge clk_sys);
    `CHK(p_busy, v)
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // read data settles after the edge, so compare at the falling edge
  always @(negedge clk_sys) begin
    if (pend && expq.size() > 0) begin
      nq = expq.pop_front();
      `CHK(sfr_rdata & nq[15:8], nq[7:0])
    end
    pend = sfr_rd;
  end
  // a hang ends the run as a failure
  initial begin
    #200000;
    fails++;
    wrap_up;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    resetn <= 1'b1;
    cyc(3);
    rd(8'hA1, 8'h07, 8'hFF);
    rd(8'hF8, 8'h06, 8'hFF);
    rd(8'h55, 8'h00, 8'hFF);
    wr(8'hA1, 8'hFF);
    rd(8'hA1, 8'h77, 8'hFF);
    wr(8'hA1, 8'h00);
    // select pin: filtered and raw views, then a short glitch
    ss_low <= 1'b1;
    cyc(6);
    rd(8'hA1, 8'h08, 8'h0C);
    ss_low <= 1'b0;
    cyc(6);
    rd(8'hA1, 8'h04, 8'h0C);
    ss_low <= 1'b1;
    cyc(1);
    ss_low <= 1'b0;
    cyc(3);
    rd(8'hA1, 8'h00, 8'h08);
    $display("test select done");
    // slave transfers in all four clock modes
    for (int i = 0; i < 4; i++) begin
      wr(8'hF8, 8'h04);
      wr(8'hA1, {2'b00, i[1:0], 4'h0});
      p_pha <= i[1];
      p_pol <= i[0];
      wr(8'hF8, 8'h05);
      seed = lfsr(seed);
      d_tx = seed[7:0];
      pt = seed[15:8];
      p_tx <= pt;
      wr(8'hA3, d_tx);
      cyc(3);
      rd(8'hA1, {2'b00, i[1:0], 4'h5}, 8'hFF);
      p_go <= 1'b1;
      wait_far(1'b1);
      p_go <= 1'b0;
      cyc(40);
      rd(8'hA1, 8'h88, 8'h8A);
      wait_far(1'b0);
      cyc(10);
      `CHK(p_rx, d_tx)
      rd(8'hA1, {2'b00, i[1:0], 4'h6}, 8'hFF);
      rd(8'hA3, pt, 8'hFF);
      rd(8'hA1, 8'h01, 8'h01);
    end
    $display("test slave done");
    // master transfers, seven cycles a half period
    wr(8'hA2, 8'h06);
    for (int i = 0; i < 4; i++) begin
      wr(8'hF8, 8'h0C);
      p_pha <= i[1];
      p_pol <= i[0];
      seed = lfsr(seed);
      d_tx = seed[7:0];
      pt = seed[15:8];
      p_tx <= pt;
      wr(8'hA1, {2'b01, i[1:0], 4'h0});
      wr(8'hF8, 8'h08);
      wr(8'hF8, 8'h09);
      wr(8'hA3, d_tx);
      cyc(40);
      rd(8'hA1, 8'h80, 8'h80);
      cyc(100);
      `CHK(p_rx, d_tx)
      rd(8'hA1, {2'b01, i[1:0], 4'hB}, 8'hFF);
      rd(8'hA3, pt, 8'hFF);
    end
    $display("test master done");
    // disabling mid-byte stops the transfer
    wr(8'hA3, 8'h5A);
    cyc(30);
    wr(8'hF8, 8'h08);
    cyc(3);
    rd(8'hA1, 8'h00, 8'h80);
    wr(8'hF8, 8'h01);
    wr(8'hF8, 8'h04);
    cyc(4);
    $display("test abort done");
    wrap_up;
  end
endmodule
`default_nettype wire
